// ==== core/fcpp_pkg.sv ====
// Purpose: Shared constants and types for the feature connector pixel port.
// Assumes: Pixel words reach the port on ref_clk; the pins face pixClk.
// Notes: Summary of operation follows.
// Summary of operation
// - Connector clock pin mirrors the DAC pixel clock.
// - Connector blank pin mirrors DAC active-low blank.
// - Connector bus pins equal DAC pixel word.
// - Memory clock observed only with debug strap.
// - Dot clock observed only with debug strap.
// - Sense pin direction follows the chip configuration.
// - Channel clock driven only for mechanism two.
// - Channel data bidirectional while any mechanism active.
package fcpp_pkg;

  // ==========================================================
  // Sizes and counts
  localparam int PIXEL_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int SYNC_STAGES = 2;

  // ==========================================================
  // Display data channel mechanism codes
  localparam logic [1:0] DDC_MECH_ONE = 2'h1;
  localparam logic [1:0] DDC_MECH_TWO = 2'h2;

  // ==========================================================
  // Values after reset
  localparam logic [PIXEL_WIDTH-1:0] PIXEL_RESET = 8'h00;
  localparam logic BLANK_N_RESET = 1'h0;
  localparam logic SYNC_RESET = 1'h0;

  typedef struct packed {
    logic hsync;
    logic vsync;
    logic blankN;
    logic [PIXEL_WIDTH-1:0] pixel;
  } fcpp_pixel_s;

  localparam int PIXEL_WORD_W = $bits(fcpp_pixel_s);

  typedef enum logic [1:0] {
    FCPP_SENSE_OFF = 2'h0,
    FCPP_SENSE_IN = 2'h1,
    FCPP_SENSE_OUT = 2'h2
  } fcpp_sense_e;

endpackage

// ==== core/fcpp_fifo.sv ====
// Purpose: Two-clock FIFO carrying pixel words from ref_clk to pixClk.
// Assumes: DEPTH is a power of two of at least four.
// Notes: Read data always comes from a register.
`timescale 1ns/10ps
module fcpp_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input wire logic wrClk,
  input wire logic wrRst,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic rdClk,
  input wire logic rdRst,
  output logic rdValid,
  input wire logic rdReady,
  output logic [WIDTH-1:0] rdData
);
  localparam int AW = $clog2(DEPTH);

  function automatic logic [AW:0] toGray(input logic [AW:0] b);
    toGray = b ^ (b >> 1);
  endfunction

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrBin_r, wrGray_r, rdBin_r, rdGray_r;
  logic [AW:0] rdGrayMeta_r, rdGraySync_r, wrGrayMeta_r, wrGraySync_r;
  logic full, empty, push, pop;

  // ==========================================================
  // Write side
  // Full compares gray codes so only one bit moves per crossing.
  assign full = wrGray_r ==
    {~rdGraySync_r[AW:AW-1], rdGraySync_r[AW-2:0]};
  assign wrReady = !full;
  assign push = wrValid && !full;

  always_ff @(posedge wrClk) begin
    if (push) begin
      mem[wrBin_r[AW-1:0]] <= wrData;
    end
  end

  always_ff @(posedge wrClk) begin
    if (wrRst) begin
      wrBin_r <= '0;
      wrGray_r <= '0;
    end else if (push) begin
      wrBin_r <= wrBin_r + 1'b1;
      wrGray_r <= toGray(wrBin_r + 1'b1);
    end
  end

  always_ff @(posedge wrClk) begin
    if (wrRst) begin
      rdGrayMeta_r <= '0;
      rdGraySync_r <= '0;
    end else begin
      rdGrayMeta_r <= rdGray_r;
      rdGraySync_r <= rdGrayMeta_r;
    end
  end

  // ==========================================================
  // Read side
  assign empty = rdGray_r == wrGraySync_r;
  assign pop = !empty && (!rdValid || rdReady);

  always_ff @(posedge rdClk) begin
    if (rdRst) begin
      wrGrayMeta_r <= '0;
      wrGraySync_r <= '0;
    end else begin
      wrGrayMeta_r <= wrGray_r;
      wrGraySync_r <= wrGrayMeta_r;
    end
  end

  always_ff @(posedge rdClk) begin
    if (rdRst) begin
      rdBin_r <= '0;
      rdGray_r <= '0;
      rdValid <= 1'b0;
      rdData <= '0;
    end else if (pop) begin
      rdBin_r <= rdBin_r + 1'b1;
      rdGray_r <= toGray(rdBin_r + 1'b1);
      rdValid <= 1'b1;
      rdData <= mem[rdBin_r[AW-1:0]];
    end else if (rdReady) begin
      rdValid <= 1'b0;
    end
  end
endmodule // fcpp_fifo

// ==== core/fcpp_port.sv ====
// Purpose: Feature connector, monitor sense and channel pin logic.
// Assumes: pixClk is the dot clock that also feeds the internal DAC.
// Notes: Pixel words cross from ref_clk through a 16-word FIFO.
`timescale 1ns/10ps
module fcpp_port #(
  parameter int PIXEL_WIDTH = fcpp_pkg::PIXEL_WIDTH,
  parameter int FIFO_DEPTH = fcpp_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pixClk,
  input wire logic memClk,
  // Pixel source on ref_clk.
  input wire logic srcValid,
  output logic srcReady,
  input wire fcpp_pkg::fcpp_pixel_s srcWord,
  // Internal DAC side on pixClk.
  output logic [PIXEL_WIDTH-1:0] dacPixel,
  output logic dacBlankN,
  output logic hsync,
  output logic vsync,
  output logic pixelUnderrun,
  // Connector pins; the enable pin is active high.
  input wire logic connectorEnableN,
  output logic connectorPixelClockOut,
  output logic connectorPixelClockOe,
  output logic connectorBlankNOut,
  output logic connectorBlankNOe,
  output logic connectorHsyncOut,
  output logic connectorVsyncOut,
  output logic connectorSyncOe,
  input wire logic [PIXEL_WIDTH-1:0] connectorPixelBusIn,
  output logic [PIXEL_WIDTH-1:0] connectorPixelBusOut,
  output logic connectorPixelBusOe,
  output logic [PIXEL_WIDTH-1:0] extDacData,
  // Strap and observation pins.
  input wire logic strapPinDebug,
  output logic memClockObserveOut,
  output logic memClockObserveOe,
  output logic dotClockObserveOut,
  output logic dotClockObserveOe,
  // Configuration straps and monitor sense pin.
  input wire logic graphicsOnlyConfig,
  input wire logic dacTestConfig,
  input wire logic synthDisableConfig,
  input wire logic dacSenseCompare,
  input wire logic senseIn,
  output logic senseOut,
  output logic senseOe,
  output logic senseStatus,
  // Display data channel pins and engine side.
  input wire logic ddcEnable,
  input wire logic [1:0] ddcMechSelect,
  input wire logic ddcClockDrive,
  input wire logic ddcDataDrive,
  input wire logic ddcDataDriveEn,
  output logic ddcDataRx,
  output logic monitorChannelClockOut,
  output logic monitorChannelClockOe,
  input wire logic monitorChannelDataIn,
  output logic monitorChannelDataOut,
  output logic monitorChannelDataOe
);

  // ==========================================================
  // Reset carried into the pixel domain
  logic pixRstMeta_r, pixRst;

  always_ff @(posedge pixClk) begin
    pixRstMeta_r <= rst;
    pixRst <= pixRstMeta_r;
  end

  // ==========================================================
  // Pixel FIFO
  fcpp_pkg::fcpp_pixel_s fifoWord;
  logic fifoValid;

  fcpp_fifo #(
    .WIDTH(fcpp_pkg::PIXEL_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .wrClk(ref_clk),
    .wrRst(rst),
    .wrValid(srcValid),
    .wrReady(srcReady),
    .wrData(srcWord),
    .rdClk(pixClk),
    .rdRst(pixRst),
    .rdValid(fifoValid),
    .rdReady(1'b1),
    .rdData(fifoWord)
  );

  // ==========================================================
  // DAC word, one per dot clock
  // An empty FIFO blanks the screen rather than repeating stale pixels.
  always_ff @(posedge pixClk) begin
    if (pixRst) begin
      dacPixel <= fcpp_pkg::PIXEL_RESET;
      dacBlankN <= fcpp_pkg::BLANK_N_RESET;
      hsync <= fcpp_pkg::SYNC_RESET;
      vsync <= fcpp_pkg::SYNC_RESET;
    end else if (fifoValid) begin
      dacPixel <= fifoWord.pixel;
      dacBlankN <= fifoWord.blankN;
      hsync <= fifoWord.hsync;
      vsync <= fifoWord.vsync;
    end else begin
      dacBlankN <= fcpp_pkg::BLANK_N_RESET;
    end
  end

  always_ff @(posedge pixClk) begin
    if (pixRst) begin
      pixelUnderrun <= 1'b0;
    end else begin
      pixelUnderrun <= !fifoValid;
    end
  end

  // ==========================================================
  // Connector enable and mirroring
  logic enMeta_r, enSync_r;

  always_ff @(posedge pixClk) begin
    if (pixRst) begin
      enMeta_r <= 1'b0;
      enSync_r <= 1'b0;
    end else begin
      enMeta_r <= connectorEnableN;
      enSync_r <= enMeta_r;
    end
  end

  assign connectorPixelClockOe = enSync_r;
  assign connectorBlankNOe = enSync_r;
  assign connectorSyncOe = enSync_r;
  assign connectorPixelBusOe = enSync_r;
  // The forwarded clock is the DAC clock itself, so no skew is added.
  assign connectorPixelClockOut = pixClk;
  assign connectorBlankNOut = dacBlankN;
  assign connectorHsyncOut = hsync;
  assign connectorVsyncOut = vsync;
  assign connectorPixelBusOut = dacPixel;

  // ==========================================================
  // External DAC data path on the shared bus pins
  logic [PIXEL_WIDTH-1:0] busMeta_r, busSync_r;

  always_ff @(posedge pixClk) begin
    if (pixRst) begin
      busMeta_r <= '0;
      busSync_r <= '0;
      extDacData <= '0;
    end else begin
      busMeta_r <= connectorPixelBusIn;
      busSync_r <= busMeta_r;
      extDacData <= enSync_r ? '0 : busSync_r;
    end
  end

  // ==========================================================
  // Debug strap caught once after reset release
  logic strapMeta_r, strapSync_r, strapDebug_r, strapCaught_r;

  // The synchroniser runs through reset, so the strap is settled at release.
  always_ff @(posedge ref_clk) begin
    strapMeta_r <= strapPinDebug;
    strapSync_r <= strapMeta_r;
  end

  // The strap is latched once so a later pin change cannot toggle it.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strapDebug_r <= 1'b0;
      strapCaught_r <= 1'b0;
    end else if (!strapCaught_r) begin
      strapDebug_r <= strapSync_r;
      strapCaught_r <= 1'b1;
    end
  end

  assign memClockObserveOut = memClk;
  assign memClockObserveOe = strapDebug_r;
  assign dotClockObserveOut = pixClk;
  assign dotClockObserveOe = strapDebug_r;

  // ==========================================================
  // Monitor sense direction
  logic [2:0] cfgMeta_r, cfgSync_r;
  logic senseMeta_r, senseSync_r;
  fcpp_pkg::fcpp_sense_e senseMode;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfgMeta_r <= '0;
      cfgSync_r <= '0;
      senseMeta_r <= 1'b0;
      senseSync_r <= 1'b0;
    end else begin
      cfgMeta_r <= {dacTestConfig, graphicsOnlyConfig,
        synthDisableConfig};
      cfgSync_r <= cfgMeta_r;
      senseMeta_r <= senseIn;
      senseSync_r <= senseMeta_r;
    end
  end

  // Test mode wins so the comparator can always be observed.
  always_comb begin
    if (cfgSync_r[2]) begin
      senseMode = fcpp_pkg::FCPP_SENSE_OUT;
    end else if (cfgSync_r[1]) begin
      senseMode = fcpp_pkg::FCPP_SENSE_IN;
    end else begin
      senseMode = fcpp_pkg::FCPP_SENSE_OFF;
    end
  end

  assign senseOe = senseMode == fcpp_pkg::FCPP_SENSE_OUT;
  assign senseOut = senseOe ? dacSenseCompare : 1'b0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      senseStatus <= 1'b0;
    end else begin
      unique case (senseMode)
        fcpp_pkg::FCPP_SENSE_IN: senseStatus <= senseSync_r;
        fcpp_pkg::FCPP_SENSE_OUT: senseStatus <= dacSenseCompare;
        fcpp_pkg::FCPP_SENSE_OFF: senseStatus <= 1'b0;
        default: senseStatus <= 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Display data channel pins
  logic ddcActive, ddcMechTwo;
  logic ddcMeta_r, ddcSync_r;

  assign ddcMechTwo = ddcEnable &&
    ddcMechSelect == fcpp_pkg::DDC_MECH_TWO;
  assign ddcActive = ddcEnable &&
    (ddcMechSelect == fcpp_pkg::DDC_MECH_ONE || ddcMechTwo);
  assign monitorChannelClockOe = ddcMechTwo;
  assign monitorChannelClockOut = ddcMechTwo && ddcClockDrive;
  assign monitorChannelDataOe = ddcActive && ddcDataDriveEn;
  assign monitorChannelDataOut = ddcDataDrive;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ddcMeta_r <= 1'b1;
      ddcSync_r <= 1'b1;
    end else begin
      ddcMeta_r <= monitorChannelDataIn;
      ddcSync_r <= ddcMeta_r;
    end
  end

  assign ddcDataRx = ddcActive ? ddcSync_r : 1'b1;

  // ==========================================================
  // Checks on the pixel domain
  sequence s_enable_rise;
    !connectorEnableN ##1 connectorEnableN [*3];
  endsequence

  sequence s_enable_fall;
    connectorEnableN ##1 !connectorEnableN [*3];
  endsequence

  a_enable_drives: assert property (@(posedge pixClk) disable iff (pixRst)
    s_enable_rise |-> connectorPixelBusOe && connectorBlankNOe)
    else $error("connector pins not driven after enable");

  a_disable_floats: assert property (@(posedge pixClk)
    disable iff (pixRst)
    s_enable_fall |-> !connectorPixelBusOe && !connectorSyncOe &&
    !connectorPixelClockOe)
    else $error("connector pins still driven after disable");

  a_clock_with_bus: assert property (@(posedge pixClk)
    disable iff (pixRst)
    $changed(connectorPixelClockOe) |->
    connectorPixelClockOe == $past(connectorEnableN, 2) &&
    connectorPixelBusOe == connectorPixelClockOe)
    else $error("connector clock enable does not follow the pin");

  a_blank_mirror: assert property (@(posedge pixClk)
    disable iff (pixRst)
    fifoValid |=> connectorBlankNOut == $past(fifoWord.blankN))
    else $error("connector blank does not follow DAC blank");

  a_bus_mirror: assert property (@(posedge pixClk) disable iff (pixRst)
    fifoValid |=> connectorPixelBusOut == $past(fifoWord.pixel))
    else $error("connector bus does not follow DAC word");

  a_ext_dac_quiet: assert property (@(posedge pixClk)
    disable iff (pixRst)
    $past(connectorPixelBusOe) |-> extDacData == '0)
    else $error("external DAC data passed while bus driven");

  // ==========================================================
  // Checks on the reference domain
  a_mem_observe: assert property (@(posedge ref_clk) disable iff (rst)
    strapCaught_r |=> $stable(memClockObserveOe))
    else $error("memory clock observe enable moved after strap");

  a_dot_observe: assert property (@(posedge ref_clk) disable iff (rst)
    (dotClockObserveOe == memClockObserveOe) and
    (!strapCaught_r |-> !dotClockObserveOe))
    else $error("dot clock observe enable wrong");

  a_sense_dir: assert property (@(posedge ref_clk) disable iff (rst)
    cfgSync_r[1] && !cfgSync_r[2] |-> !senseOe ##1
    senseStatus == $past(senseSync_r))
    else $error("sense pin driven in graphics only setting");

  a_channel_clock: assert property (@(posedge ref_clk) disable iff (rst)
    monitorChannelClockOe |-> ddcEnable &&
    ddcMechSelect == fcpp_pkg::DDC_MECH_TWO)
    else $error("channel clock driven without mechanism two");

  a_channel_data: assert property (@(posedge ref_clk) disable iff (rst)
    !ddcActive |-> !monitorChannelDataOe && ddcDataRx)
    else $error("channel data active without a mechanism");

endmodule // fcpp_port

// ==== tb/fcpp_far_model.sv ====
// Purpose: Far-side model of the feature connector board and monitor.
// Assumes: The board drives the shared bus only while the port lets go.
// Notes: The monitor data line has a pull-up and may be pulled low.
`timescale 1ns/10ps
module fcpp_far_model (
  input wire logic [7:0] busOut,
  input wire logic busOe,
  input wire logic [7:0] boardData,
  output logic [7:0] busWire,
  input wire logic chanOut,
  input wire logic chanOe,
  input wire logic monPull,
  output logic chanWire
);
  // ==========================================================
  // Shared pin resolution
  // The board feeds the external DAC path whenever the port lets go.
  assign busWire = busOe ? busOut : boardData;
  // A released data line rises through the pull-up unless the monitor pulls it low, never a stale value.
  assign chanWire = chanOe ? chanOut : !monPull;
endmodule // fcpp_far_model

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the feature connector pixel port.
// Assumes: pixClk runs free at 30 ns, ref_clk at 5 ns.
// Notes: Inputs change 1 ns after the ref_clk edge.
`timescale 1ns/10ps
module testbench;
  logic ref_clk = 1'b0, pixClk = 1'b0, memClk = 1'b0, rst = 1'b1;
  logic srcValid = 1'b0, srcReady, sawFull = 1'b0, watch = 1'b0;
  fcpp_pkg::fcpp_pixel_s srcWord = '0;
  logic [7:0] dacPixel, busIn, busOut, extDacData, boardData = 8'h5A;
  logic dacBlankN, hsync, vsync, pixelUnderrun, enable = 1'b0;
  logic pcOut, pcOe, bnOut, bnOe, hsOut, vsOut, syncOe, busOe;
  logic strap = 1'b0, mcOut, mcOe, dcOut, dcOe;
  logic gOnly = 1'b0, dTest = 1'b0, sDis = 1'b0, cmp = 1'b0;
  logic senseIn = 1'b0, senseOut, senseOe, senseStatus;
  logic ddcEn = 1'b0, ckDrv = 1'b0, dDrv = 1'b0, dDrvEn = 1'b0, ddcRx;
  logic [1:0] mech = 2'h0;
  logic chClkOut, chClkOe, chDataIn, chDataOut, chDataOe;
  logic monPull = 1'b0;
  logic [7:0] expQ[$];
  logic [7:0] expPix;
  logic [1:0] expSense;
  int err_count = 0, samples_checked = 0, cycles = 0;

  // ==========================================================
  // Clocks and timeout
  always #2.5 ref_clk = ~ref_clk;
  always #8.5 memClk = ~memClk;
  // The odd start keeps the dot clock out of phase with ref_clk.
  initial begin
    #1.7;
    forever #15 pixClk = ~pixClk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  fcpp_port i_fcpp_port (.ref_clk(ref_clk), .rst(rst), .pixClk(pixClk),
    .memClk(memClk), .srcValid(srcValid), .srcReady(srcReady),
    .srcWord(srcWord), .dacPixel(dacPixel), .dacBlankN(dacBlankN),
    .hsync(hsync), .vsync(vsync), .pixelUnderrun(pixelUnderrun),
    .connectorEnableN(enable), .connectorPixelClockOut(pcOut),
    .connectorPixelClockOe(pcOe), .connectorBlankNOut(bnOut),
    .connectorBlankNOe(bnOe), .connectorHsyncOut(hsOut),
    .connectorVsyncOut(vsOut), .connectorSyncOe(syncOe),
    .connectorPixelBusIn(busIn), .connectorPixelBusOut(busOut),
    .connectorPixelBusOe(busOe), .extDacData(extDacData),
    .strapPinDebug(strap), .memClockObserveOut(mcOut),
    .memClockObserveOe(mcOe), .dotClockObserveOut(dcOut),
    .dotClockObserveOe(dcOe), .graphicsOnlyConfig(gOnly),
    .dacTestConfig(dTest), .synthDisableConfig(sDis),
    .dacSenseCompare(cmp), .senseIn(senseIn), .senseOut(senseOut),
    .senseOe(senseOe), .senseStatus(senseStatus), .ddcEnable(ddcEn),
    .ddcMechSelect(mech), .ddcClockDrive(ckDrv), .ddcDataDrive(dDrv),
    .ddcDataDriveEn(dDrvEn), .ddcDataRx(ddcRx),
    .monitorChannelClockOut(chClkOut), .monitorChannelClockOe(chClkOe),
    .monitorChannelDataIn(chDataIn), .monitorChannelDataOut(chDataOut),
    .monitorChannelDataOe(chDataOe));

  fcpp_far_model i_fcpp_far_model (.busOut(busOut), .busOe(busOe),
    .boardData(boardData), .busWire(busIn), .chanOut(chDataOut),
    .chanOe(chDataOe), .monPull(monPull), .chanWire(chDataIn));

  // ==========================================================
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic pstep(input int n);
    repeat (n) @(posedge pixClk);
    step(1);
  endtask

  // Reset spans eight dot clocks so the slow domain sees enough edges.
  task automatic do_reset();
    rst = 1'b1;
    repeat (8) @(posedge pixClk);
    step(1);
    rst = 1'b0;
  endtask

  // Readiness is sampled late in the cycle, where it has settled.
  task automatic push(input int n);
    logic rdy;
    int i;
    i = 0;
    while (i < n) begin
      srcValid = 1'b1;
      srcWord = '{hsync: i[0], vsync: i[1], blankN: 1'b1,
                  pixel: 8'hA0 + i[7:0]};
      #3;
      rdy = srcReady;
      if (rdy !== 1'b1) sawFull = 1'b1;
      step(1);
      if (rdy === 1'b1) begin
        expQ.push_back(8'hA0 + i[7:0]);
        i++;
      end
    end
    srcValid = 1'b0;
  endtask

  task automatic end_of_test();
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Pin mirror monitor
  always @(negedge pixClk) begin
    if (watch && dacBlankN === 1'b1) begin
      expPix = expQ.size() > 0 ? expQ.pop_front() : 8'hFF;
      chk(dacPixel, expPix);
      chk(busOut, expPix);
      chk(bnOut, 1'b1);
      chk({vsOut, hsOut, vsync, hsync}, {2{expPix[1:0]}});
      chk(pcOut, 1'b0);
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    do_reset();
    chk({busOe, pcOe, bnOe, syncOe, mcOe, dcOe, chClkOe, chDataOe}, 0);
    chk(ddcRx, 16'h1);
    step(12);
    chk({mcOe, dcOe}, 16'h0);
    pstep(6);
    chk(extDacData, 16'h5A);
    enable = 1'b1;
    pstep(4);
    chk({pcOe, bnOe, syncOe, busOe}, 16'hF);
    @(posedge pixClk);
    #1;
    chk(pcOut, 16'h1);
    step(1);
    watch = 1'b1;
    push(20);
    chk(sawFull, 16'h1);
    pstep(30);
    chk(16'(expQ.size()), 16'h0);
    chk({pixelUnderrun, dacBlankN}, 16'h2);
    chk(extDacData, 16'h0);
    watch = 1'b0;
    enable = 1'b0;
    boardData = 8'hC3;
    pstep(6);
    chk({pcOe, bnOe, syncOe, busOe}, 16'h0);
    chk(extDacData, 16'hC3);
    strap = 1'b1;
    do_reset();
    step(12);
    chk({mcOe, dcOe}, 16'h3);
    @(posedge memClk);
    #1;
    chk(mcOut, 16'h1);
    @(negedge pixClk);
    #1;
    chk(dcOut, 16'h0);
    step(1);
    for (int k = 0; k < 3; k++) begin
      {gOnly, dTest, sDis} = 3'h4 >> k;
      for (int v = 0; v < 2; v++) begin
        senseIn = v[0];
        cmp = !v[0];
        step(6);
        expSense = {k == 1, k == 0 ? v[0] : k == 1 && !v[0]};
        chk({senseOe, senseStatus}, expSense);
        if (k == 1) chk(senseOut, !v[0]);
      end
    end
    {ckDrv, dDrv} = 2'h3;
    for (int e = 0; e < 2; e++) begin
      for (int m = 0; m < 3; m++) begin
        ddcEn = e[0];
        mech = m[1:0];
        dDrvEn = 1'b1;
        monPull = 1'b0;
        step(1);
        chk({chClkOe, chClkOut}, {2{e == 1 && m == 2}});
        chk({chDataOe, chDataOut}, {e == 1 && m != 0, 1'b1});
        dDrvEn = 1'b0;
        monPull = 1'b1;
        step(6);
        chk({chDataOe, ddcRx}, {1'b0, !(e == 1 && m != 0)});
      end
    end
    end_of_test();
  end
endmodule // testbench
